// >>> rtl/fifo_host_defs.svh
// constants for the host controller of the 64-word handshake fifo
`ifndef FIFO_HOST_DEFS_SVH
`define FIFO_HOST_DEFS_SVH

`define WORD_W       9
`define DEV_DEPTH    64
`define BUF_DEPTH    32
`define CHAIN_LEN    1
`define CHAIN_CAP    (`CHAIN_LEN * (`DEV_DEPTH - 1) + 1)

`define CLK_NS       100
`define T_PMR_NS     55
`define T_DSI_NS     25
`define T_PHSI_NS    23
`define T_PLSI_NS    25
`define T_HSI_NS     30
`define T_PHSO_NS    23
`define T_PLSO_NS    25

`define CYC_UP(ns)   ((((ns) + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : (((ns) + `CLK_NS - 1) / `CLK_NS))

`endif

// >>> rtl/fifo_host_pkg.sv
// types for the host controller of the 64-word handshake fifo
package fifo_host_pkg;
	typedef enum logic [2:0] {
		W_CLR    = 3'b000,
		W_SETTLE = 3'b001,
		W_IDLE   = 3'b010,
		W_HIGH   = 3'b011,
		W_LOW    = 3'b100
	} wr_state_t;
	typedef enum logic [1:0] {
		R_IDLE = 2'b00,
		R_HIGH = 2'b01,
		R_LOW  = 2'b10
	} rd_state_t;
endpackage : fifo_host_pkg

// >>> rtl/word_stream_if.sv
// valid/ready word stream between the controller and its buffer
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

// >>> rtl/stream_buffer.sv
// parameterised first-in first-out word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_buffer #(
	parameter int W = 9,
	parameter int D = 32
) (
	input  wire logic   clk,
	input  wire logic   rst_n,
	word_stream_if.snk  wr,
	word_stream_if.src  rd
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wptr_q;
	logic [AW:0]  rptr_q;
	wire          empty  = (wptr_q == rptr_q);
	wire          full   = (wptr_q[AW-1:0] == rptr_q[AW-1:0]) && (wptr_q[AW] != rptr_q[AW]);
	wire          push   = wr.valid && !full;
	wire          pop    = rd.ready && !empty;

	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data  = mem[rptr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			if (push) wptr_q <= wptr_q + (AW+1)'(1);
			if (pop)  rptr_q <= rptr_q + (AW+1)'(1);
		end
	end
endmodule : stream_buffer
`default_nettype wire

// >>> rtl/fifo_host.sv
// host controller that loads and unloads a 64-word handshake fifo through its pins
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"
module fifo_host
	import fifo_host_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire logic               clear_req,
	input  wire logic               in_valid,
	input  wire logic [`WORD_W-1:0] in_data,
	output logic                    in_ready,
	output logic                    out_valid,
	output logic [`WORD_W-1:0]      out_data,
	input  wire logic               out_ready,
	output logic                    link_up,
	output logic                    level_near_bound,
	output logic                    level_half,
	output logic                    master_clear_n,
	output logic                    shift_in_strobe,
	output logic [`WORD_W-1:0]      in_word,
	input  wire logic               space_avail,
	output logic                    shift_out_strobe,
	input  wire logic [`WORD_W-1:0] out_word,
	input  wire logic               data_valid_out,
	input  wire logic               near_bound_flag,
	input  wire logic               half_level_flag
);
	localparam logic [3:0] PMR_CYC  = 4'(`CYC_UP(`T_PMR_NS));
	localparam logic [3:0] DSI_CYC  = 4'(`CYC_UP(`T_DSI_NS));
	localparam logic [3:0] PHSI_CYC = 4'(`CYC_UP(`T_PHSI_NS));
	localparam logic [3:0] PLSI_CYC = 4'(`CYC_UP(`T_PLSI_NS > `T_HSI_NS ? `T_PLSI_NS : `T_HSI_NS));
	localparam logic [3:0] PHSO_CYC = 4'(`CYC_UP(`T_PHSO_NS));
	localparam logic [3:0] PLSO_CYC = 4'(`CYC_UP(`T_PLSO_NS));
	localparam int         SYNC_W   = `WORD_W + 4;

	// true once a phase has lasted its least number of cycles
	function automatic logic held(input logic [3:0] cnt, input logic [3:0] need);
		return ({1'b0, cnt} + 5'h01) >= {1'b0, need};
	endfunction : held

	// phase counter restarts on every state change and sticks at its top value
	function automatic logic [3:0] next_cnt(input logic moved, input logic [3:0] cnt);
		if (moved) begin
			return 4'h0;
		end
		return (cnt == 4'hf) ? cnt : cnt + 4'h1;
	endfunction : next_cnt

	// two-flop synchronisers for every pin from the device
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {space_avail, data_valid_out, near_bound_flag, half_level_flag, out_word};
			sync2_q <= sync1_q;
		end
	end
	wire               space_s = sync2_q[SYNC_W-1];
	wire               valid_s = sync2_q[SYNC_W-2];
	wire [`WORD_W-1:0] word_s  = sync2_q[`WORD_W-1:0];
	wire               near_s  = sync2_q[SYNC_W-3];
	wire               half_s  = sync2_q[SYNC_W-4];
	// word and valid pass the same two stages; the word settles before valid rises,
	// so a word taken with a synced valid is already stable

	// flags are only ever looked at as levels; short pulses pass through harmlessly
	assign level_near_bound = near_s;
	assign level_half       = half_s;

	word_stream_if #(.W(`WORD_W)) fill_if ();
	word_stream_if #(.W(`WORD_W)) drain_if ();

	assign fill_if.valid = in_valid;
	assign fill_if.data  = in_data;
	assign in_ready      = fill_if.ready;

	stream_buffer #(.W(`WORD_W), .D(`BUF_DEPTH)) u_buffer (
		.clk   (mclk),
		.rst_n (nrst),
		.wr    (fill_if.snk),
		.rd    (drain_if.src)
	);

	// ---------------- write side ----------------
	wr_state_t         wst_q;
	wr_state_t         wst_d;
	logic [3:0]        wcnt_q;
	logic [`WORD_W-1:0] in_word_q;

	wire wr_idle     = (wst_q == W_IDLE);
	wire wr_high     = (wst_q == W_HIGH);
	wire wr_live     = (wst_q != W_CLR) && (wst_q != W_SETTLE);
	wire clr_done    = held(wcnt_q, PMR_CYC);
	wire settle_done = held(wcnt_q, DSI_CYC);
	wire si_low_done = held(wcnt_q, PLSI_CYC);

	// the strobe rises only on a synced space level and falls only once that level
	// has dropped or on a clear request, so the pulse is never cut short at the full boundary
	wire start_wr = wr_idle && drain_if.valid && space_s;
	wire si_drop  = wr_high && held(wcnt_q, PHSI_CYC) && !space_s;
	// the buffer word is retired when the strobe falls, the commit edge
	assign drain_if.ready = si_drop;

	always_comb begin
		wst_d = wst_q;
		unique case (wst_q)
			W_CLR:    if (clr_done) wst_d = W_SETTLE;
			W_SETTLE: if (settle_done) wst_d = W_IDLE;
			W_IDLE:   if (start_wr) wst_d = W_HIGH;
			W_HIGH:   if (si_drop) wst_d = W_LOW;
			W_LOW:    if (si_low_done) wst_d = W_IDLE;
			default:  wst_d = W_CLR;
		endcase
		// a clear request restarts the pulse; words already buffered are sent after it
		if (clear_req) wst_d = W_CLR;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wst_q  <= W_CLR;
			wcnt_q <= '0;
		end else begin
			wst_q  <= wst_d;
			wcnt_q <= next_cnt(wst_d != wst_q, wcnt_q);
		end
	end

	// the word is set up with the rising strobe and held through the low phase
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			in_word_q <= '0;
		end else if (start_wr && !clear_req) begin
			in_word_q <= drain_if.data;
		end
	end

	assign in_word         = in_word_q;
	assign shift_in_strobe = wr_high;
	assign master_clear_n  = (wst_q != W_CLR);
	assign link_up         = wr_live;

	// ---------------- read side ----------------
	rd_state_t          rst_q;
	rd_state_t          rst_d;
	logic [3:0]         rcnt_q;
	logic [`WORD_W-1:0] out_data_q;
	logic               out_valid_q;

	wire rd_idle     = (rst_q == R_IDLE);
	wire rd_high     = (rst_q == R_HIGH);
	wire so_low_done = held(rcnt_q, PLSO_CYC);

	// an output word is only taken while the device says it is valid and stable
	wire start_rd = rd_idle && link_up && valid_s && !out_valid_q;
	wire so_drop  = rd_high && held(rcnt_q, PHSO_CYC) && !valid_s;

	always_comb begin
		rst_d = rst_q;
		unique case (rst_q)
			R_IDLE:  if (start_rd) rst_d = R_HIGH;
			R_HIGH:  if (so_drop) rst_d = R_LOW;
			R_LOW:   if (so_low_done) rst_d = R_IDLE;
			default: rst_d = R_IDLE;
		endcase
		if (!link_up) rst_d = R_IDLE;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_q  <= R_IDLE;
			rcnt_q <= '0;
		end else begin
			rst_q  <= rst_d;
			rcnt_q <= next_cnt(rst_d != rst_q, rcnt_q);
		end
	end

	// capture happens as the strobe rises, like a flop clocked by the strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			out_data_q  <= '0;
			out_valid_q <= 1'b0;
		end else if (start_rd) begin
			out_data_q  <= word_s;
			out_valid_q <= 1'b1;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	// handshake alone paces both strobes, so any chain depth works, including N*63+1
	// one strobe per six cycles at most stays well below the fast-cascade rate,
	// so the far side needs no inverted space-to-shift-out link
	assign shift_out_strobe = rd_high;
	assign out_valid        = out_valid_q;
	assign out_data         = out_data_q;
endmodule : fifo_host
`default_nettype wire

// >>> verif/host_checks_assertions.sv
// pin protocol checks for the fifo host
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"
module host_checks (
	input wire logic               mclk,
	input wire logic               nrst,
	input wire logic               link_up,
	input wire logic               master_clear_n,
	input wire logic               shift_in_strobe,
	input wire logic [`WORD_W-1:0] in_word,
	input wire logic               space_avail,
	input wire logic               shift_out_strobe,
	input wire logic               data_valid_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_clear_quiet: assert property (!master_clear_n |-> !shift_in_strobe)
		else $error("shift in during clear");
	a_clear_gap: assert property ($rose(master_clear_n) |-> !shift_in_strobe)
		else $error("shift in as clear ends");
	a_read_linked: assert property ($rose(shift_out_strobe) |-> $past(link_up))
		else $error("shift out before link");
	a_si_space: assert property ($rose(shift_in_strobe) |->
		$past(space_avail, 2) || $past(space_avail, 3))
		else $error("shift in without space");
	a_si_fall: assert property ($fell(shift_in_strobe) |->
		!$past(space_avail, 2) || !$past(space_avail, 3))
		else $error("shift in fell before capture");
	a_so_valid: assert property ($rose(shift_out_strobe) |->
		$past(data_valid_out, 2) || $past(data_valid_out, 3))
		else $error("shift out without valid");
	a_si_low: assert property ($fell(shift_in_strobe) |=> !shift_in_strobe)
		else $error("shift in low too short");
	a_so_low: assert property ($fell(shift_out_strobe) |=> !shift_out_strobe)
		else $error("shift out low too short");
	a_word_hold: assert property (shift_in_strobe && $past(shift_in_strobe) |->
		$stable(in_word))
		else $error("input word moved");
endmodule : host_checks
bind fifo_host host_checks chk_u (.mclk(mclk), .nrst(nrst), .link_up(link_up),
	.master_clear_n(master_clear_n), .shift_in_strobe(shift_in_strobe), .in_word(in_word),
	.space_avail(space_avail), .shift_out_strobe(shift_out_strobe),
	.data_valid_out(data_valid_out));
`default_nettype wire

// >>> verif/fifo_dev_model.sv
// behavioural model of the 64-word handshake fifo device
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model #(parameter int DEPTH = 64) (
	input  wire logic       master_clear_n,
	input  wire logic       shift_in_strobe,
	input  wire logic [8:0] in_word,
	output logic            space_avail,
	input  wire logic       shift_out_strobe,
	output logic [8:0]      out_word,
	output logic            data_valid_out,
	output logic            near_bound_flag,
	output logic            half_level_flag
);
	logic [8:0] mem [DEPTH];
	logic [8:0] cap;
	int         wp, rp;
	bit         took, pend;
	assign near_bound_flag = wp - rp <= 8 || wp - rp >= DEPTH - 8;
	assign half_level_flag = wp - rp >= DEPTH / 2;
	// level-sensitive so a clear that is already low at time zero is not missed
	always begin
		wait (master_clear_n === 1'b0);
		wp = 0;
		rp = 0;
		took = 0;
		pend = 0;
		out_word = 9'h000;
		data_valid_out = 0;
		space_avail = 1;
		wait (master_clear_n !== 1'b0);
	end
	always @(posedge shift_in_strobe) if (space_avail && master_clear_n) begin
		cap = in_word;
		took = 1;
		#5 space_avail = 0;
	end
	always @(negedge shift_in_strobe) if (took) begin
		mem[wp % DEPTH] = cap;
		wp++;
		took = 0;
		#5 space_avail = wp - rp < DEPTH;
	end
	always @(posedge shift_out_strobe) if (data_valid_out) begin
		pend = 1;
		#5 data_valid_out = 0;
	end
	always @(negedge shift_out_strobe) if (pend) begin
		rp++;
		pend = 0;
		#5 if (!took) space_avail = 1;
	end
	always @(wp or rp or data_valid_out or pend) if (!data_valid_out && !pend && wp > rp) begin
		#10 out_word = mem[rp % DEPTH];
		#5 data_valid_out = 1;
		if (shift_out_strobe) begin
			pend = 1;
			#10 data_valid_out = 0;
		end
	end
endmodule : fifo_dev_model
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench for the fifo host against the device model
`timescale 1ns/1ps
`default_nettype none
`include "fifo_host_defs.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	logic               mclk, nrst, clear_req, in_valid, out_ready, in_ready, out_valid;
	logic [`WORD_W-1:0] in_data, out_data, in_word, out_word;
	logic               link_up, level_near_bound, level_half, master_clear_n;
	logic               shift_in_strobe, shift_out_strobe, space_avail, data_valid_out;
	logic               near_bound_flag, half_level_flag;
	int                 errors, num_checks, dev;
	fifo_host dut_u (.mclk, .nrst, .clear_req, .in_valid, .in_data, .in_ready, .out_valid,
		.out_data, .out_ready, .link_up, .level_near_bound, .level_half, .master_clear_n,
		.shift_in_strobe, .in_word, .space_avail, .shift_out_strobe, .out_word,
		.data_valid_out, .near_bound_flag, .half_level_flag);
	fifo_dev_model dev_u (.master_clear_n, .shift_in_strobe, .in_word, .space_avail,
		.shift_out_strobe, .out_word, .data_valid_out, .near_bound_flag, .half_level_flag);
	initial begin
		mclk = 0;
		forever #50 mclk = ~mclk;
	end
	function automatic logic [8:0] wrd(int n);
		return 9'(n * 7) ^ 9'h0a5;
	endfunction : wrd
	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic push(logic [8:0] w);
		in_valid = 1;
		in_data = w;
		for (int k = 0; k < 50 && in_ready !== 1'b1; k++) cyc(1);
		cyc(1);
		in_valid = 0;
		cyc(1);
	endtask : push
	task automatic pull(logic [8:0] e);
		for (int k = 0; k < 60 && out_valid !== 1'b1; k++) cyc(1);
		`CHK(out_valid, 1'b1)
		`CHK(out_data, e)
		out_ready = 1;
		cyc(1);
		out_ready = 0;
	endtask : pull
	task automatic t_reset;
		for (int k = 0; k < 10 && link_up !== 1'b1; k++) cyc(1);
		`CHK(link_up, 1'b1)
		`CHK(level_near_bound, 1'b1)
		`CHK(level_half, 1'b0)
		`CHK(out_valid, 1'b0)
	endtask : t_reset
	task automatic t_fill;
		for (int n = 0; n < 97; n++) begin
			push(wrd(n));
			cyc(25);
			dev = n < 64 ? n : 64;
			`CHK(level_near_bound, 1'(dev <= 8 || dev >= 56))
			`CHK(level_half, 1'(dev >= 32))
			`CHK(in_ready, 1'(n < 96))
		end
	endtask : t_fill
	task automatic t_drain;
		for (int n = 0; n < 97; n++) pull(wrd(n));
		cyc(25);
		`CHK(out_valid, 1'b0)
		`CHK(level_near_bound, 1'b1)
		`CHK(in_ready, 1'b1)
	endtask : t_drain
	task automatic t_clear;
		for (int n = 0; n < 40; n++) push(wrd(n));
		// the host buffer empties into the device at about six cycles per word
		cyc(300);
		`CHK(level_half, 1'b1)
		clear_req = 1;
		cyc(1);
		`CHK(master_clear_n, 1'b0)
		clear_req = 0;
		cyc(25);
		`CHK(level_half, 1'b0)
		`CHK(level_near_bound, 1'b1)
		`CHK(link_up, 1'b1)
	endtask : t_clear
	task automatic summarize;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	initial begin
		nrst = 0;
		clear_req = 0;
		in_valid = 0;
		in_data = 9'h000;
		out_ready = 0;
		repeat (4) @(posedge mclk);
		#1 nrst = 1;
		t_reset();
		t_fill();
		t_drain();
		t_clear();
		summarize();
	end
	initial begin
		#(20000 * `CLK_NS);
		errors++;
		summarize();
	end
endmodule : tb
`default_nettype wire
